/* File: fmsb_pkg.sv */
// Shared constants and types of the fieldbus master status block.
package fmsb_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int unsigned STATIONS = 127;
	localparam int unsigned MAP_BITS = 128;
	localparam int unsigned STATION_AW = 7;
	localparam int unsigned NUM_EVENTS = 5;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [11:0] OFS_MODULE = 12'h000;
	localparam logic [11:0] OFS_SIGNATURE = 12'h004;
	localparam logic [11:0] OFS_COUNT = 12'h008;
	localparam logic [11:0] OFS_SWITCHOVER = 12'h00C;
	localparam logic [11:0] OFS_IRQ_STATUS = 12'h010;
	localparam logic [11:0] OFS_IRQ_MASK = 12'h014;
	localparam logic [11:0] OFS_ONLINE = 12'h020;
	localparam logic [11:0] OFS_EXCHANGE = 12'h030;
	localparam logic [11:0] OFS_ALARM = 12'h040;
	localparam logic [11:0] OFS_DIAG = 12'h050;
	localparam logic [11:0] MAP_GROUP_MASK = 12'hFF0;

	// ----------------------------------------------------------------
	// Event bit positions of the interrupt status register
	// ----------------------------------------------------------------
	localparam int unsigned EV_MODE = 0;
	localparam int unsigned EV_CONFIG = 1;
	localparam int unsigned EV_ONLINE = 2;
	localparam int unsigned EV_ALARM = 3;
	localparam int unsigned EV_DIAG = 4;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] RST_SIGNATURE = 32'h0000_0000;
	localparam logic [4:0] RST_MASK = 5'h00;
	localparam logic [31:0] SWITCHOVER_VALUE = 32'h0000_0000;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		FMSB_MODE_OFFLINE = 4'h1,
		FMSB_MODE_STOPPED = 4'h2,
		FMSB_MODE_CLEAR = 4'h4,
		FMSB_MODE_OPERATE = 4'h8
	} fmsb_mode_t;

	// Bit 0 of the module status word is the offline flag, bit 4 the slave flag.
	typedef struct packed {
		logic slave_emulation_flag;
		logic master_operate_flag;
		logic master_clear_flag;
		logic master_stopped_flag;
		logic master_offline_flag;
	} fmsb_flags_t;

	typedef struct packed {
		logic online;
		logic exchange;
		logic alarm;
		logic diag;
	} fmsb_station_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} fmsb_apb_req_t;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} fmsb_apb_rsp_t;

endpackage

/* File: fmsb_station_map.sv */
// One per-station bitmap with single-bit writes and a registered word read.
`timescale 1ns/10ps
module fmsb_station_map #(
	parameter int unsigned N = 128,
	parameter int unsigned LIMIT = 127,
	parameter int unsigned AW = 7,
	parameter int unsigned IW = 2
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic wr_bit,
	output logic old_bit,
	input wire logic [IW-1:0] rd_index,
	output logic [31:0] rd_word
);

	typedef struct packed {
		logic [N-1:0] bits;
		logic [31:0] word;
	} fmsb_map_state_t;

	fmsb_map_state_t state;
	fmsb_map_state_t next_state;

	assign old_bit = state.bits[wr_addr];
	assign rd_word = state.word;

	// Addresses at or above the limit are never written, so bit 127 reads 0.
	always_comb begin
		next_state = state;
		if (wr_en && (32'(wr_addr) < LIMIT)) begin
			next_state.bits[wr_addr] = wr_bit;
		end
		next_state.word = state.bits[32'(rd_index) * 32 +: 32];
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

endmodule

/* File: fmsb_irq.sv */
// Sticky event status with write-one-to-clear, a mask and one level interrupt.
`timescale 1ns/10ps
module fmsb_irq #(
	parameter int unsigned N = 5,
	parameter logic [N-1:0] MASK_RESET = '0
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic [N-1:0] event_in,
	input wire logic status_we,
	input wire logic mask_we,
	input wire logic [N-1:0] wdata,
	output logic [N-1:0] status,
	output logic [N-1:0] mask,
	output logic irq
);

	typedef struct packed {
		logic [N-1:0] status;
		logic [N-1:0] mask;
		logic irq;
	} fmsb_irq_state_t;

	fmsb_irq_state_t state;
	fmsb_irq_state_t next_state;

	assign status = state.status;
	assign mask = state.mask;
	assign irq = state.irq;

	// An event in the clearing cycle wins, so no event is ever lost.
	always_comb begin
		next_state = state;
		if (status_we) begin
			next_state.status = state.status & ~wdata;
		end
		next_state.status = next_state.status | event_in;
		if (mask_we) begin
			next_state.mask = wdata;
		end
		next_state.irq = |(next_state.status & next_state.mask);
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			state <= '{status: '0, mask: MASK_RESET, irq: 1'b0};
		end else begin
			state <= next_state;
		end
	end

endmodule

/* File: fmsb_status_block.sv */
// Fieldbus master status register bank with APB access and event interrupt.
`timescale 1ns/10ps

// Overview of operation
// - Stopped flag high only in stopped mode
// - Clear flag high only in clear mode
// - Operate flag high only in operational mode
// - Slave flag high while emulating slave stations
// - Signature updates when new configuration loads
// - Count equals stations exchanging data
// - Online map, one bit per station
// - Exchange map bit while exchanging data
// - Alarm map bit while alarm pending
// - Diagnostics map bit while diagnostics pending
// - Offline flag high only in offline mode
// - Status word mirrors all boolean flags
module fmsb_status_block #(
	parameter int unsigned MAP_N = fmsb_pkg::MAP_BITS,
	parameter int unsigned LIMIT = fmsb_pkg::STATIONS
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire fmsb_pkg::fmsb_apb_req_t apb_req,
	output fmsb_pkg::fmsb_apb_rsp_t apb_rsp,
	input wire fmsb_pkg::fmsb_mode_t master_mode,
	input wire logic slave_emulation,
	input wire logic config_load,
	input wire logic [31:0] config_value,
	input wire logic station_upd_valid,
	input wire logic [6:0] station_upd_addr,
	input wire fmsb_pkg::fmsb_station_t station_upd,
	output fmsb_pkg::fmsb_flags_t status_flags,
	output logic [7:0] active_station_count,
	output logic irq
);

	// ----------------------------------------------------------------
	// Read source selection, captured in the setup cycle
	// ----------------------------------------------------------------
	typedef enum logic [5:0] {
		FMSB_SEL_LOCAL = 6'h01,
		FMSB_SEL_ONLINE = 6'h02,
		FMSB_SEL_EXCHANGE = 6'h04,
		FMSB_SEL_ALARM = 6'h08,
		FMSB_SEL_DIAG = 6'h10,
		FMSB_SEL_ERROR = 6'h20
	} fmsb_sel_t;

	typedef struct packed {
		fmsb_pkg::fmsb_flags_t flags;
		logic [31:0] config_signature;
		logic [7:0] count;
		fmsb_sel_t sel;
		logic [31:0] local_word;
	} fmsb_main_state_t;

	fmsb_main_state_t state;
	fmsb_main_state_t next_state;

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	logic setup_phase;
	logic access_phase;
	logic write_access;
	logic [11:0] group;
	logic [1:0] word_index;
	logic status_we;
	logic mask_we;

	assign setup_phase = apb_req.psel && !apb_req.penable;
	assign access_phase = apb_req.psel && apb_req.penable;
	assign write_access = access_phase && apb_req.pwrite;
	assign group = apb_req.paddr & fmsb_pkg::MAP_GROUP_MASK;
	assign word_index = apb_req.paddr[3:2];
	assign status_we = write_access && (apb_req.paddr == fmsb_pkg::OFS_IRQ_STATUS);
	assign mask_we = write_access && (apb_req.paddr == fmsb_pkg::OFS_IRQ_MASK);

	// ----------------------------------------------------------------
	// Station maps
	// ----------------------------------------------------------------
	logic upd_en;
	logic eff_exchange;
	logic old_online;
	logic old_exchange;
	logic old_alarm;
	logic old_diag;
	logic [31:0] online_word;
	logic [31:0] exchange_word;
	logic [31:0] alarm_word;
	logic [31:0] diag_word;

	assign upd_en = station_upd_valid && (32'(station_upd_addr) < LIMIT);
	// A station cannot exchange data unless it is also online.
	assign eff_exchange = station_upd.exchange && station_upd.online;

	fmsb_station_map #(.N(MAP_N), .LIMIT(LIMIT), .AW(7), .IW(2)) u_online (
		.clock(clock),
		.reset_n(reset_n),
		.wr_en(upd_en),
		.wr_addr(station_upd_addr),
		.wr_bit(station_upd.online),
		.old_bit(old_online),
		.rd_index(word_index),
		.rd_word(online_word)
	);

	fmsb_station_map #(.N(MAP_N), .LIMIT(LIMIT), .AW(7), .IW(2)) u_exchange (
		.clock(clock),
		.reset_n(reset_n),
		.wr_en(upd_en),
		.wr_addr(station_upd_addr),
		.wr_bit(eff_exchange),
		.old_bit(old_exchange),
		.rd_index(word_index),
		.rd_word(exchange_word)
	);

	fmsb_station_map #(.N(MAP_N), .LIMIT(LIMIT), .AW(7), .IW(2)) u_alarm (
		.clock(clock),
		.reset_n(reset_n),
		.wr_en(upd_en),
		.wr_addr(station_upd_addr),
		.wr_bit(station_upd.alarm),
		.old_bit(old_alarm),
		.rd_index(word_index),
		.rd_word(alarm_word)
	);

	fmsb_station_map #(.N(MAP_N), .LIMIT(LIMIT), .AW(7), .IW(2)) u_diag (
		.clock(clock),
		.reset_n(reset_n),
		.wr_en(upd_en),
		.wr_addr(station_upd_addr),
		.wr_bit(station_upd.diag),
		.old_bit(old_diag),
		.rd_index(word_index),
		.rd_word(diag_word)
	);

	// ----------------------------------------------------------------
	// Events and interrupt
	// ----------------------------------------------------------------
	fmsb_pkg::fmsb_flags_t new_flags;
	logic [fmsb_pkg::NUM_EVENTS-1:0] events;
	logic [fmsb_pkg::NUM_EVENTS-1:0] irq_status;
	logic [fmsb_pkg::NUM_EVENTS-1:0] irq_mask;

	always_comb begin
		new_flags.master_offline_flag = (master_mode == fmsb_pkg::FMSB_MODE_OFFLINE);
		new_flags.master_stopped_flag = (master_mode == fmsb_pkg::FMSB_MODE_STOPPED);
		new_flags.master_clear_flag = (master_mode == fmsb_pkg::FMSB_MODE_CLEAR);
		new_flags.master_operate_flag = (master_mode == fmsb_pkg::FMSB_MODE_OPERATE);
		new_flags.slave_emulation_flag = slave_emulation;
	end

	// Only rising alarm and diagnostics bits raise events; unloading is silent.
	always_comb begin
		events = '0;
		events[fmsb_pkg::EV_MODE] = (new_flags != state.flags);
		events[fmsb_pkg::EV_CONFIG] = config_load;
		events[fmsb_pkg::EV_ONLINE] = upd_en && (station_upd.online != old_online);
		events[fmsb_pkg::EV_ALARM] = upd_en && station_upd.alarm && !old_alarm;
		events[fmsb_pkg::EV_DIAG] = upd_en && station_upd.diag && !old_diag;
	end

	fmsb_irq #(.N(fmsb_pkg::NUM_EVENTS), .MASK_RESET(fmsb_pkg::RST_MASK)) u_irq (
		.clock(clock),
		.reset_n(reset_n),
		.event_in(events),
		.status_we(status_we),
		.mask_we(mask_we),
		.wdata(apb_req.pwdata[fmsb_pkg::NUM_EVENTS-1:0]),
		.status(irq_status),
		.mask(irq_mask),
		.irq(irq)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_state = state;
		next_state.flags = new_flags;
		if (config_load) begin
			next_state.config_signature = config_value;
		end
		// The count tracks the exchange map incrementally instead of a 127-bit adder tree.
		if (upd_en && (eff_exchange != old_exchange)) begin
			if (eff_exchange) begin
				next_state.count = state.count + 8'h01;
			end else begin
				next_state.count = state.count - 8'h01;
			end
		end
		if (setup_phase) begin
			next_state.local_word = 32'h0000_0000;
			next_state.sel = FMSB_SEL_LOCAL;
			case (apb_req.paddr)
				fmsb_pkg::OFS_MODULE: begin
					next_state.local_word = {27'h0, state.flags};
				end
				fmsb_pkg::OFS_SIGNATURE: begin
					next_state.local_word = state.config_signature;
				end
				fmsb_pkg::OFS_COUNT: begin
					next_state.local_word = {24'h0, state.count};
				end
				fmsb_pkg::OFS_SWITCHOVER: begin
					next_state.local_word = fmsb_pkg::SWITCHOVER_VALUE;
				end
				fmsb_pkg::OFS_IRQ_STATUS: begin
					next_state.local_word = {27'h0, irq_status};
				end
				fmsb_pkg::OFS_IRQ_MASK: begin
					next_state.local_word = {27'h0, irq_mask};
				end
				default: begin
					case (group)
						fmsb_pkg::OFS_ONLINE: begin
							next_state.sel = FMSB_SEL_ONLINE;
						end
						fmsb_pkg::OFS_EXCHANGE: begin
							next_state.sel = FMSB_SEL_EXCHANGE;
						end
						fmsb_pkg::OFS_ALARM: begin
							next_state.sel = FMSB_SEL_ALARM;
						end
						fmsb_pkg::OFS_DIAG: begin
							next_state.sel = FMSB_SEL_DIAG;
						end
						default: begin
							next_state.sel = FMSB_SEL_ERROR;
						end
					endcase
					if (apb_req.paddr[1:0] != 2'h0) begin
						next_state.sel = FMSB_SEL_ERROR;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			state <= '{flags: '0, config_signature: fmsb_pkg::RST_SIGNATURE,
				count: 8'h00, sel: FMSB_SEL_LOCAL, local_word: 32'h0000_0000};
		end else begin
			state <= next_state;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Read words were all registered at the setup edge; only the select muxes them here.
	always_comb begin
		apb_rsp.pready = access_phase;
		apb_rsp.pslverr = access_phase && (state.sel == FMSB_SEL_ERROR);
		case (state.sel)
			FMSB_SEL_LOCAL: begin
				apb_rsp.prdata = state.local_word;
			end
			FMSB_SEL_ONLINE: begin
				apb_rsp.prdata = online_word;
			end
			FMSB_SEL_EXCHANGE: begin
				apb_rsp.prdata = exchange_word;
			end
			FMSB_SEL_ALARM: begin
				apb_rsp.prdata = alarm_word;
			end
			FMSB_SEL_DIAG: begin
				apb_rsp.prdata = diag_word;
			end
			default: begin
				apb_rsp.prdata = 32'h0000_0000;
			end
		endcase
	end

	assign status_flags = state.flags;
	assign active_station_count = state.count;

endmodule

/* File: fmsb_status_block_monitor.sv */
// Concurrent checks on the ports of the fieldbus master status block.
`timescale 1ns/10ps
module fmsb_status_block_monitor (
	input wire logic clock,
	input wire logic reset_n,
	input wire fmsb_pkg::fmsb_apb_req_t apb_req,
	input wire fmsb_pkg::fmsb_apb_rsp_t apb_rsp,
	input wire fmsb_pkg::fmsb_mode_t master_mode,
	input wire logic slave_emulation,
	input wire logic config_load,
	input wire logic [31:0] config_value,
	input wire logic station_upd_valid,
	input wire logic [6:0] station_upd_addr,
	input wire fmsb_pkg::fmsb_station_t station_upd,
	input wire fmsb_pkg::fmsb_flags_t status_flags,
	input wire logic [7:0] active_station_count,
	input wire logic irq
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);
	a_stop_flag: assert property ($past(reset_n) |-> status_flags.master_stopped_flag ==
		($past(master_mode) == fmsb_pkg::FMSB_MODE_STOPPED)) else $error("stopped flag wrong");
	a_clear_flag: assert property ($past(reset_n) |-> status_flags.master_clear_flag ==
		($past(master_mode) == fmsb_pkg::FMSB_MODE_CLEAR)) else $error("clear flag wrong");
	a_operate_flag: assert property ($past(reset_n) |-> status_flags.master_operate_flag ==
		($past(master_mode) == fmsb_pkg::FMSB_MODE_OPERATE)) else $error("operate flag wrong");
	a_offline_flag: assert property ($past(reset_n) |-> status_flags.master_offline_flag ==
		($past(master_mode) == fmsb_pkg::FMSB_MODE_OFFLINE)) else $error("offline flag wrong");
	a_slave_flag: assert property ($past(reset_n) |->
		status_flags.slave_emulation_flag == $past(slave_emulation)) else $error("slave flag wrong");
	a_one_mode: assert property ($onehot0(status_flags[3:0])) else $error("two modes at once");
	a_count_hold: assert property ($past(reset_n) &&
		!($past(station_upd_valid) && $past(station_upd_addr) != 7'h7F)
		|-> $stable(active_station_count)) else $error("count moved without update");
	a_count_offline: assert property ($past(reset_n) && $past(station_upd_valid) &&
		!$past(station_upd.online) |-> active_station_count <= $past(active_station_count))
		else $error("offline station counted");
	a_count_max: assert property (active_station_count <= 8'h7F) else $error("count too big");
	a_ready_now: assert property (apb_rsp.pready == (apb_req.psel && apb_req.penable))
		else $error("pready wrong");
	cover property (irq);
	cover property (status_flags.master_operate_flag);
	cover property ($past(station_upd_valid) && active_station_count == 8'h02);
endmodule

bind fmsb_status_block fmsb_status_block_monitor u_fmsb_status_block_monitor (.clock(clock),
	.reset_n(reset_n), .apb_req(apb_req), .apb_rsp(apb_rsp), .master_mode(master_mode),
	.slave_emulation(slave_emulation), .config_load(config_load), .config_value(config_value),
	.station_upd_valid(station_upd_valid), .station_upd_addr(station_upd_addr),
	.station_upd(station_upd), .status_flags(status_flags),
	.active_station_count(active_station_count), .irq(irq));

/* File: fmsb_station_model.sv */
// Behavioural model of the slave stations that report their state to the block.
`timescale 1ns/10ps
module fmsb_station_model (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic req,
	input wire logic [6:0] req_addr,
	input wire fmsb_pkg::fmsb_station_t req_rec,
	output logic upd_valid,
	output logic [6:0] upd_addr,
	output fmsb_pkg::fmsb_station_t upd
);
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			upd_valid <= 1'b0;
			upd_addr <= 7'h00;
			upd <= '0;
		end else if (req) begin
			upd_valid <= 1'b1;
			upd_addr <= req_addr;
			upd <= req_rec;
		end else begin
			// Idle lines carry junk, so a design that samples them late is caught.
			upd_valid <= 1'b0;
			upd_addr <= ~upd_addr;
			upd <= fmsb_pkg::fmsb_station_t'(~upd);
		end
	end
endmodule

/* File: fmsb_status_block_test.sv */
// Self-checking testbench of the fieldbus master status block.
`timescale 1ns/10ps
module fmsb_status_block_test;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	fmsb_pkg::fmsb_apb_req_t req = '0;
	fmsb_pkg::fmsb_apb_rsp_t rsp;
	fmsb_pkg::fmsb_mode_t mode = fmsb_pkg::FMSB_MODE_OFFLINE;
	logic slave = 1'b0;
	logic cfg_ld = 1'b0;
	logic [31:0] cfg_val = 32'h0;
	logic sq = 1'b0;
	logic [6:0] sa = 7'h00;
	fmsb_pkg::fmsb_station_t sr = '0;
	logic upd_v;
	logic [6:0] upd_a;
	fmsb_pkg::fmsb_station_t upd_r;
	fmsb_pkg::fmsb_flags_t flags;
	logic [7:0] cnt;
	logic irq;
	int num_errors = 0;
	int n_tests = 0;
	int cycles = 0;
	logic [31:0] rdat;
	logic rerr;
	logic [3:0] codes [5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3};
	// An undefined mode code clears all four mode flags.
	logic [3:0] fl [5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h0};
	logic [11:0] ma;
	logic [31:0] cv [2] = '{32'hA5C3_1E07, 32'h0000_FFFF};
	logic [31:0] ex [4][4] = '{'{32'h1, 32'h1, 32'h0, 32'h4000_0000},
		'{32'h1, 32'h0, 32'h0, 32'h4000_0000}, '{32'h8000_0000, 32'h0, 32'h0, 32'h4000_0000},
		'{32'h8000_0000, 32'h0, 32'h0, 32'h4000_0000}};

	fmsb_status_block u_fmsb_status_block (.clock(clock), .reset_n(reset_n), .apb_req(req),
		.apb_rsp(rsp), .master_mode(mode), .slave_emulation(slave), .config_load(cfg_ld),
		.config_value(cfg_val), .station_upd_valid(upd_v), .station_upd_addr(upd_a),
		.station_upd(upd_r), .status_flags(flags), .active_station_count(cnt), .irq(irq));
	fmsb_station_model u_fmsb_station_model (.clock(clock), .reset_n(reset_n), .req(sq),
		.req_addr(sa), .req_rec(sr), .upd_valid(upd_v), .upd_addr(upd_a), .upd(upd_r));

	initial begin
		forever #5 clock = ~clock;
	end

	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			num_errors++;
			end_sim();
		end
	end

	task end_sim;
		if (num_errors == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// ----------------------------------------------------------------
	// Bus and station drivers
	// ----------------------------------------------------------------
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clock);
		req <= {1'b1, 1'b0, w, a, d};
		@(posedge clock);
		req.penable <= 1'b1;
		// Sample in mid-cycle: these are the values that stand at the next rising edge.
		@(negedge clock);
		while (rsp.pready !== 1'b1) @(negedge clock);
		rdat = rsp.prdata;
		rerr = rsp.pslverr;
		@(posedge clock);
		req <= '0;
	endtask

	task rd(input logic [11:0] a, input logic [31:0] exp, input logic err, input string nm);
		apb(1'b0, a, 32'h0);
		chk(nm, rdat, exp);
		chk("pslverr", {31'h0, rerr}, {31'h0, err});
	endtask

	task sta(input logic [6:0] a, input logic [3:0] r);
		@(posedge clock);
		sq <= 1'b1;
		sa <= a;
		sr <= fmsb_pkg::fmsb_station_t'(r);
	endtask

	task settle;
		@(posedge clock);
		sq <= 1'b0;
		cfg_ld <= 1'b0;
		repeat (3) @(posedge clock);
	endtask

	initial begin
		repeat (4) @(posedge clock);
		reset_n <= 1'b1;
		// The reset mode is offline, so the offline flag is up one edge after release.
		rd(fmsb_pkg::OFS_MODULE, 32'h1, 1'b0, "module");
		rd(fmsb_pkg::OFS_SWITCHOVER, 32'h0, 1'b0, "switchover");
		rd(12'h100, 32'h0, 1'b1, "unmapped");
		rd(12'h021, 32'h0, 1'b1, "misaligned");
		foreach (codes[i]) begin
			@(posedge clock);
			mode <= fmsb_pkg::fmsb_mode_t'(codes[i]);
			slave <= i[0];
			repeat (2) @(posedge clock);
			chk("flags", {27'h0, flags}, {27'h0, i[0], fl[i]});
			rd(fmsb_pkg::OFS_MODULE, {27'h0, i[0], fl[i]}, 1'b0, "module");
		end
		for (int i = 0; i < 2; i++) begin
			@(posedge clock);
			cfg_ld <= 1'b1;
			cfg_val <= cv[i];
			settle();
			rd(fmsb_pkg::OFS_SIGNATURE, cv[i], 1'b0, "signature");
		end
		// Back-to-back updates; address 127 must be dropped.
		sta(7'd0, 4'hC);
		sta(7'd126, 4'hF);
		sta(7'h7F, 4'hF);
		sta(7'd31, 4'h7);
		sta(7'd32, 4'h8);
		settle();
		chk("count", {24'h0, cnt}, 32'h2);
		rd(fmsb_pkg::OFS_COUNT, 32'h2, 1'b0, "count");
		for (int m = 0; m < 4; m++) begin
			for (int k = 0; k < 4; k++) begin
				ma = fmsb_pkg::OFS_ONLINE + 12'(16 * m + 4 * k);
				rd(ma, ex[m][k], 1'b0, "map");
			end
		end
		sta(7'd126, 4'h0);
		settle();
		chk("count", {24'h0, cnt}, 32'h1);
		rd(fmsb_pkg::OFS_ALARM + 12'h00C, 32'h0, 1'b0, "alarm");
		rd(fmsb_pkg::OFS_DIAG + 12'h00C, 32'h0, 1'b0, "diag");
		chk("irq", {31'h0, irq}, 32'h0);
		rd(fmsb_pkg::OFS_IRQ_STATUS, 32'h1F, 1'b0, "irq_status");
		apb(1'b1, fmsb_pkg::OFS_IRQ_MASK, 32'h8);
		repeat (2) @(posedge clock);
		chk("irq", {31'h0, irq}, 32'h1);
		rd(fmsb_pkg::OFS_IRQ_MASK, 32'h8, 1'b0, "irq_mask");
		apb(1'b1, fmsb_pkg::OFS_IRQ_STATUS, 32'h8);
		repeat (2) @(posedge clock);
		chk("irq", {31'h0, irq}, 32'h0);
		rd(fmsb_pkg::OFS_IRQ_STATUS, 32'h17, 1'b0, "irq_status");
		sta(7'd5, 4'h2);
		settle();
		chk("irq", {31'h0, irq}, 32'h1);
		apb(1'b1, fmsb_pkg::OFS_MODULE, 32'hFFFF_FFFF);
		chk("pslverr", {31'h0, rerr}, 32'h0);
		rd(fmsb_pkg::OFS_MODULE, 32'h0, 1'b0, "module");
		end_sim();
	end
endmodule
